// ===== rtl/page_wait_prom.sv
// Registered-mode page PROM with an active-low wait output.
// Assumes the processor samples the wait line on the falling edge and ties it
// to both its hold and data strobe inputs.
//
// Functional notes
// - Wait output launched from falling edge, seen first in access's second cycle.
// - One wait line drives hold and data strobe; strobe stands two cycles.
// - Page-crossing access holds the processor for two wait cycles.
// - Same-page access registers address on rising edge, data with no wait.
// - Only page-select address changes start a page change, not low or bank bits.
// - No page change and no new wait start while chip enable is inactive; a running wait still counts down.
`timescale 1ns/1ns
module page_wait_prom
    import page_wait_pkg::*;
#(
    parameter int unsigned WAIT_CYCLES = OFF_PAGE_WAITS,
    parameter logic [DATA_W*(1<<DEPTH_W)-1:0] CONTENTS = '0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic chip_enable_n,
    input wire logic [PAGE_ADDR_W-1:0] page_select_addr,
    input wire logic [LOW_ADDR_W-1:0] byte_select_addr,
    input wire logic bank_select_one,
    input wire logic bank_select_two,
    output logic [DATA_W-1:0] data_out,
    output logic data_valid,
    output logic wait_n
);


    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    // The wait counter is two bits wide, so only one to three waits fit.
    if (WAIT_CYCLES < 1 || WAIT_CYCLES > 3) begin : g_bad_waits
        $error("WAIT_CYCLES must lie between 1 and 3.");
    end

    // ------------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] mem [0:(1<<DEPTH_W)-1];
    logic [PAGE_ADDR_W-1:0] page_r;
    logic [PAGE_ADDR_W-1:0] addr_page_r;
    logic [LOW_ADDR_W-1:0] addr_low_r;
    logic [1:0] wait_cnt_r;
    logic page_miss;
    logic busy;
    logic [PAGE_ADDR_W-1:0] read_page;
    logic [LOW_ADDR_W-1:0] read_low;

    // The array contents are fixed by the parameter and never written.
    always_comb begin
        for (int i = 0; i < (1 << DEPTH_W); i++) begin
            mem[i] = CONTENTS[i*DATA_W +: DATA_W];
        end
    end

    // ------------------------------------------------------------------
    // Address registers and page tracking
    // ------------------------------------------------------------------
    // Bank selects only steer which device answers, so they play no part here.
    assign busy = (wait_cnt_r != WAIT_CNT_RST);
    assign page_miss = !chip_enable_n && !busy && (page_select_addr != page_r);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_page_r <= PAGE_RST;
            addr_low_r <= '0;
        end else if (!busy) begin
            addr_page_r <= page_select_addr;
            addr_low_r <= byte_select_addr;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            page_r <= PAGE_RST;
        end else if (page_miss) begin
            page_r <= page_select_addr;
        end
    end

    // ------------------------------------------------------------------
    // Wait sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt_r <= WAIT_CNT_RST;
        end else if (page_miss) begin
            wait_cnt_r <= 2'(WAIT_CYCLES);
        end else if (busy) begin
            wait_cnt_r <= wait_cnt_r - 2'h1;
        end
    end

    // The wait line changes on the falling edge so the processor sees it first
    // in the second cycle of the access.
    always_ff @(negedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_n <= 1'b1;
        end else begin
            wait_n <= !busy;
        end
    end

    // ------------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------------
    // Outside a wait the word at the address being taken is read, so same-page
    // data follows the taking edge directly. During a wait the frozen address
    // is read again, so the word strobed in at the end of the wait belongs to
    // the new page and overwrites the early capture.
    assign read_page = busy ? addr_page_r : page_select_addr;
    assign read_low = busy ? addr_low_r : byte_select_addr;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= '0;
        end else begin
            data_out <= mem[{read_page, read_low}];
        end
    end

    // Valid marks a same-page word taken with the chip enabled.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_valid <= 1'b0;
        end else begin
            data_valid <= !busy && !page_miss && !chip_enable_n;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // The wait line is still high at the taking edge and low one edge later.
    AST_MISS_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n)
        page_miss |-> wait_n ##1 !wait_n)
        else $error("Wait not raised after page miss.");

    // The line stays low for two rising edges and is released at the third.
    AST_WAIT_LEN: assert property (@(posedge core_clk) disable iff (!rst_n)
        page_miss |=> (!wait_n)[*2] ##1 wait_n)
        else $error("Wait length wrong.");

    // The taken address may not move while the waits run.
    AST_ADDR_FROZEN: assert property (@(posedge core_clk) disable iff (!rst_n)
        busy |=> $stable(addr_page_r) && $stable(addr_low_r))
        else $error("Address moved during wait.");

    // During a wait the word of the frozen address is on the data lines.
    AST_REFETCH: assert property (@(posedge core_clk) disable iff (!rst_n)
        busy |=> data_out == mem[{addr_page_r, addr_low_r}])
        else $error("Wrong word during wait.");

    // The last wait cycle always ends the sequence.
    AST_WAIT_END: assert property (@(posedge core_clk) disable iff (!rst_n)
        busy && wait_cnt_r == 2'h1 |=> !busy)
        else $error("Wait sequence overran.");

    AST_NO_CE: assert property (@(posedge core_clk) disable iff (!rst_n)
        chip_enable_n && !busy |=> !busy) else $error("Wait started while disabled.");
    AST_SAME_PAGE: assert property (@(posedge core_clk) disable iff (!rst_n)
        !chip_enable_n && !busy && page_select_addr == page_r |=> !busy)
        else $error("Wait on same-page access.");
    AST_PAGE_HELD: assert property (@(posedge core_clk) disable iff (!rst_n)
        !page_miss |=> $stable(page_r)) else $error("Page changed without miss.");
    AST_RELEASE: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(busy) |=> ##1 !busy) else $error("Wait not released.");
    AST_VALID: assert property (@(posedge core_clk) disable iff (!rst_n)
        !busy && !chip_enable_n && page_select_addr == page_r |=> data_valid)
        else $error("Same-page data not valid next cycle.");
    AST_NO_VALID: assert property (@(posedge core_clk) disable iff (!rst_n)
        busy |=> !data_valid) else $error("Data valid during wait.");

    COV_MISS: cover property (@(posedge core_clk) disable iff (!rst_n) page_miss);
    COV_HIT: cover property (@(posedge core_clk) disable iff (!rst_n) data_valid ##1 data_valid);

    // A page miss followed by same-page data once the waits have ended.
    COV_MISS_HIT: cover property (@(posedge core_clk) disable iff (!rst_n)
        page_miss ##4 data_valid);

    // A new page presented while the chip is disabled.
    COV_CE_OFF: cover property (@(posedge core_clk) disable iff (!rst_n)
        chip_enable_n && page_select_addr != page_r);
endmodule

// ===== rtl/page_wait_pkg.sv
// Constants for the page PROM wait-state block.
// Assumes a single 20 MHz system clock shared with the fetching processor.
package page_wait_pkg;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned PAGE_ADDR_W = 10;
    localparam int unsigned LOW_ADDR_W = 6;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned DEPTH_W = PAGE_ADDR_W + LOW_ADDR_W;
    // Off-page access takes two wait cycles.
    localparam int unsigned OFF_PAGE_WAITS = 2;
    // Same-page data is valid at most this long after the rising edge.
    localparam int unsigned ON_PAGE_ACCESS_NS = 20;
    localparam int unsigned ON_PAGE_ACCESS_CYC =
        (ON_PAGE_ACCESS_NS / CLK_PERIOD_NS) < 1 ? 1 : ON_PAGE_ACCESS_NS / CLK_PERIOD_NS;
    localparam logic [1:0] WAIT_CNT_RST = 2'h0;
    localparam logic [PAGE_ADDR_W-1:0] PAGE_RST = 10'h000;
endpackage

// ===== sim/fetch_model.sv
// Fetch side model: holds on a low wait line and strobes data while held.
// Assumes the one wait line feeds both its hold and its strobe input.
`timescale 1ns/1ns
module fetch_model
    import page_wait_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wait_n,
    input wire logic [DATA_W-1:0] data_out,
    output logic [DATA_W-1:0] instr_r
);
    logic frozen_r;
    // Hold is sampled on the falling edge.
    always_ff @(negedge core_clk or negedge rst_n) frozen_r <= !rst_n ? 1'b0 : !wait_n;
    // A capture made before the hold is seen is overwritten by the strobe.
    always_ff @(posedge core_clk or negedge rst_n)
        instr_r <= !rst_n ? '0 : (!frozen_r || !wait_n) ? data_out : instr_r;
endmodule

// ===== sim/prom_page_wait_interface_tb.sv
// Self-checking bench for the page PROM wait block.
// Assumes the design package and the fetch model are compiled first.
`timescale 1ns/1ns
module prom_page_wait_interface_tb;
    import page_wait_pkg::*;
    logic core_clk = 0, rst_n = 0, ce_n = 1, b1 = 0, dv, wait_n;
    logic [PAGE_ADDR_W-1:0] pg = '0;
    logic [LOW_ADDR_W-1:0] by = '0;
    logic [DATA_W-1:0] dout, instr;
    int miscompares = 0, total_checks = 0;
    always #25 core_clk = ~core_clk;
    page_wait_prom #(.CONTENTS({(1<<DEPTH_W){8'h5a}})) page_wait_prom_inst (
        .core_clk(core_clk), .rst_n(rst_n), .chip_enable_n(ce_n), .page_select_addr(pg),
        .byte_select_addr(by), .bank_select_one(b1), .bank_select_two(~b1),
        .data_out(dout), .data_valid(dv), .wait_n(wait_n));
    fetch_model fetch_model_inst (.core_clk(core_clk), .rst_n(rst_n), .wait_n(wait_n),
        .data_out(dout), .instr_r(instr));
    task check(input int got, input int exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: count %0d not %0d", $time, got, exp);
        end
    endtask
    task check_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: data %h not %h", $time, got, exp);
        end
    endtask
    // Takes one access, then counts low wait samples and flags any valid data for 8 cycles.
    task run(input logic c, input logic [PAGE_ADDR_W-1:0] p, input int xw, xf, xv);
        int w, f, v;
        w = 0;
        f = 0;
        v = 0;
        @(negedge core_clk);
        ce_n = c;
        pg = p;
        by = by + 6'h01;
        b1 = ~b1;
        @(posedge core_clk);
        // Each sample stands just before a falling edge, as the fetch side sees it.
        for (int k = 1; k <= 8; k++) begin
            #20;
            if (wait_n === 1'b0 && f == 0) f = k;
            if (wait_n === 1'b0) w++;
            if (dv === 1'b1) v = 1;
            @(posedge core_clk);
        end
        #1;
        check(w, xw);
        check(f, xf);
        check(v, xv);
    endtask
    task test_hit;
        run(1'b0, 10'h000, 0, 0, 1);
        check_data(dout, 8'h5a);
    endtask
    task test_miss;
        run(1'b0, 10'h003, 2, 2, 1);
        check_data(instr, 8'h5a);
    endtask
    task test_ce_off;
        run(1'b1, 10'h009, 0, 0, 0);
        run(1'b0, 10'h003, 0, 0, 1);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge core_clk);
        check_data(dout, 8'h00);
        check_data({7'h00, wait_n}, 8'h01);
        rst_n = 1;
        test_hit();
        test_miss();
        test_ce_off();
        run(1'b0, 10'h3ff, 2, 2, 1);
        give_verdict();
    end
    initial begin
        #(400 * CLK_PERIOD_NS);
        miscompares++;
        give_verdict();
    end
endmodule
